// file: frame_filter_pkg.sv
// Purpose: Shared constants and types for the receive frame pattern filter
// Assumes: Pattern of 512 bits held as 16 words of 32 bits, lowest word first
// Notes:   Byte n of the frame sits at pattern bits [8n+7:8n]
package frame_filter_pkg;

    localparam int NUM_FILTERS  = 4;
    localparam int NUM_AVB      = 3;
    localparam int NUM_UNITS    = NUM_FILTERS + NUM_AVB;
    localparam int VERDICT_W    = NUM_FILTERS + 1;
    localparam int PAT_BITS     = 512;
    localparam int PAT_WORDS    = 16;
    localparam int PAT_BYTES    = 64;
    localparam int BYTE_IDX_W   = 7;

    localparam logic [BYTE_IDX_W-1:0] BYTE_IDX_RESET = 7'h00;
    localparam logic [31:0]           RD_DATA_RESET  = 32'h0000_0000;

    // AVB bank positions inside the bank
    localparam logic [1:0] AVB_PTP     = 2'h0;
    localparam logic [1:0] AVB_CLASS_A = 2'h1;
    localparam logic [1:0] AVB_CLASS_B = 2'h2;

    // Broadcast match: ones in the low 48 bits of value and mask
    localparam logic [PAT_BITS-1:0] BCAST_INIT = 512'hFFFF_FFFF_FFFF;

    // Bytes 15:12 hold type then type info, little-endian
    localparam logic [PAT_BITS-1:0] PTP_VAL_INIT  = 512'hF788_0000_0000_0000_0000_0000_0000;
    localparam logic [PAT_BITS-1:0] PTP_MASK_INIT = 512'hFFFF_0000_0000_0000_0000_0000_0000;
    localparam logic [PAT_BITS-1:0] SRA_VAL_INIT  = 512'h0260_0081_0000_0000_0000_0000_0000_0000;
    localparam logic [PAT_BITS-1:0] SRB_VAL_INIT  = 512'h0240_0081_0000_0000_0000_0000_0000_0000;
    localparam logic [PAT_BITS-1:0] SR_MASK_INIT  = 512'hFFFF_FFFF_0000_0000_0000_0000_0000_0000;

    localparam logic [PAT_BITS-1:0] AVB_VAL_INIT  [NUM_AVB] = '{PTP_VAL_INIT, SRA_VAL_INIT, SRB_VAL_INIT};
    localparam logic [PAT_BITS-1:0] AVB_MASK_INIT [NUM_AVB] = '{PTP_MASK_INIT, SR_MASK_INIT, SR_MASK_INIT};

    typedef struct packed {
        logic       avb_bank_redirect;
        logic [3:0] index;
    } filter_ctrl_t;

    localparam filter_ctrl_t CTRL_RESET = '{avb_bank_redirect: 1'b0, index: 4'h0};

    typedef struct packed {
        logic        is_mask;
        logic [3:0]  word;
        logic [31:0] data;
    } pattern_write_t;

    typedef struct packed {
        logic       valid;
        logic       last;
        logic       good;
        logic [7:0] data;
    } rx_beat_t;

    function automatic logic [7:0] lane_byte(input logic [31:0] word, input logic [1:0] lane);
        lane_byte = word[{lane, 3'b000} +: 8];
    endfunction

endpackage

// file: pattern_match_unit.sv
// Purpose: One value/mask pattern store and its running compare
// Assumes: Byte index counts from zero at the first frame byte
// Notes:   Hit is combinational and includes the byte on the current beat
`timescale 1ns/1ps
module pattern_match_unit #(
    parameter logic [511:0] VAL_INIT  = 512'h0,
    parameter logic [511:0] MASK_INIT = 512'h0
) (
    input  wire logic                            clk_sys,
    input  wire logic                            rst_n,
    input  wire logic                            wr_en,
    input  wire frame_filter_pkg::pattern_write_t wr,
    input  wire logic                            rd_is_mask,
    input  wire logic [3:0]                      rd_word,
    output logic      [31:0]                     rd_data,
    input  wire logic                            beat_en,
    input  wire logic [5:0]                      byte_idx,
    input  wire logic [7:0]                      rx_byte,
    input  wire logic                            enable,
    output logic                                 hit
);

    logic [31:0] val_mem  [frame_filter_pkg::PAT_WORDS];
    logic [31:0] mask_mem [frame_filter_pkg::PAT_WORDS];
    logic        miss_reg;
    logic [7:0]  val_byte;
    logic [7:0]  mask_byte;
    logic        byte_miss;
    logic        first_beat;
    logic        prior_miss;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < frame_filter_pkg::PAT_WORDS; i++) begin
                val_mem[i]  <= VAL_INIT[32*i +: 32];
                mask_mem[i] <= MASK_INIT[32*i +: 32];
            end
        end else if (wr_en) begin
            if (wr.is_mask) begin
                mask_mem[wr.word] <= wr.data;
            end else begin
                val_mem[wr.word] <= wr.data;
            end
        end
    end

    assign rd_data    = rd_is_mask ? mask_mem[rd_word] : val_mem[rd_word];
    // Byte n lives in word n/4, lane n%4, so byte order is little-endian
    assign val_byte   = frame_filter_pkg::lane_byte(val_mem[byte_idx[5:2]], byte_idx[1:0]);
    assign mask_byte  = frame_filter_pkg::lane_byte(mask_mem[byte_idx[5:2]], byte_idx[1:0]);
    assign byte_miss  = beat_en && (((rx_byte ^ val_byte) & mask_byte) != 8'h00);
    assign first_beat = beat_en && (byte_idx == 6'h00);
    assign prior_miss = miss_reg && !first_beat;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            miss_reg <= 1'b0;
        end else if (beat_en) begin
            miss_reg <= prior_miss || byte_miss;
        end
    end

    assign hit = enable && !(prior_miss || byte_miss);

endmodule // pattern_match_unit

// file: rx_frame_pattern_filter.sv
// Purpose: Receive frame filter with pattern filters, AVB bank and drop verdicts
// Assumes: One byte per beat; da_match and rx.good are valid on the last beat
// Notes:   Verdict outputs update on the last beat and hold until the next one
`timescale 1ns/1ps
module rx_frame_pattern_filter (
    input  wire logic                                       clk_sys,
    input  wire logic                                       rst_n,
    input  wire logic                                       promiscuous,
    input  wire logic [frame_filter_pkg::NUM_FILTERS-1:0]   filter_en,
    input  wire logic [frame_filter_pkg::NUM_AVB-1:0]       avb_filter_en,
    input  wire logic                                       ctrl_wr,
    input  wire frame_filter_pkg::filter_ctrl_t             ctrl_in,
    input  wire logic                                       pat_wr,
    input  wire frame_filter_pkg::pattern_write_t           pat_in,
    input  wire logic                                       pat_rd_is_mask,
    input  wire logic [3:0]                                 pat_rd_word,
    input  wire frame_filter_pkg::rx_beat_t                 rx,
    input  wire logic                                       da_match,
    output frame_filter_pkg::filter_ctrl_t                  ctrl_reg,
    output logic [31:0]                                     pat_rd_data_reg,
    output logic [frame_filter_pkg::VERDICT_W-1:0]          verdict_reg,
    output logic                                            verdict_valid_reg,
    output logic                                            frame_good_reg,
    output logic                                            av_match_reg,
    output logic                                            ptp_match_reg
);

    localparam int NF = frame_filter_pkg::NUM_FILTERS;
    localparam int NA = frame_filter_pkg::NUM_AVB;
    localparam int NU = frame_filter_pkg::NUM_UNITS;

    logic [frame_filter_pkg::BYTE_IDX_W-1:0] byte_idx_reg;
    logic [frame_filter_pkg::BYTE_IDX_W-1:0] byte_idx_next;
    logic                                    beat_en;
    logic                                    frame_end;
    logic [NU-1:0]                           unit_wr;
    logic [NU-1:0]                           unit_en;
    logic [NU-1:0]                           unit_hit;
    logic [31:0]                             unit_rd [NU];
    logic [31:0]                             rd_sel;
    logic [NF-1:0]                           pat_hit;
    logic                                    any_pat_hit;
    logic [NU-1:0]                           unit_sel;
    logic [frame_filter_pkg::VERDICT_W-1:0]  verdict_next;
    logic                                    frame_good_next;
    logic                                    av_match_next;
    logic                                    ptp_match_next;

    // Selection of the filter that value/mask accesses reach
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= frame_filter_pkg::CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_reg <= ctrl_in;
        end
    end

    // True when the selection addresses unit u; the AVB bank decodes only index[1:0], so AVB low bits 3 and absent configurable filters address none
    function automatic logic unit_selected(input frame_filter_pkg::filter_ctrl_t sel, input int u);
        unit_selected = 1'b0;
        if (u < NF) begin
            unit_selected = !sel.avb_bank_redirect && (sel.index == 4'(u));
        end else if (u < NF + NA) begin
            unit_selected = sel.avb_bank_redirect && (sel.index[1:0] == 2'(u - NF));
        end
    endfunction

    // One-hot decode of the current selection; at most one unit is addressed
    always_comb begin
        for (int u = 0; u < NU; u++) begin
            unit_sel[u] = unit_selected(ctrl_reg, u);
        end
    end

    // Writes reach only the selected unit, using the selection held before this edge
    assign unit_wr = unit_sel & {NU{pat_wr}};

    // An absent selection reads as zero
    always_comb begin
        rd_sel = frame_filter_pkg::RD_DATA_RESET;
        for (int u = 0; u < NU; u++) begin
            if (unit_sel[u]) begin
                rd_sel = unit_rd[u];
            end
        end
    end

    // Read data is registered so the port comes straight from a flip-flop
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pat_rd_data_reg <= frame_filter_pkg::RD_DATA_RESET;
        end else begin
            pat_rd_data_reg <= rd_sel;
        end
    end

    // Byte position within the frame, saturating past the pattern window
    assign beat_en   = rx.valid && !byte_idx_reg[6];
    assign frame_end = rx.valid && rx.last;

    always_comb begin
        byte_idx_next = byte_idx_reg;
        if (frame_end) begin
            byte_idx_next = frame_filter_pkg::BYTE_IDX_RESET;
        end else if (beat_en) begin
            byte_idx_next = byte_idx_reg + 7'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            byte_idx_reg <= frame_filter_pkg::BYTE_IDX_RESET;
        end else begin
            byte_idx_reg <= byte_idx_next;
        end
    end

    // Enables act at the last beat, so clearing one mid frame takes effect at once
    assign unit_en = {avb_filter_en, filter_en};

    // Configurable filters reset to broadcast, AVB filters to PTP and the two SR classes
    genvar g;
    generate
        for (g = 0; g < NU; g++) begin : g_unit
            pattern_match_unit #(
                .VAL_INIT  ((g < NF) ? frame_filter_pkg::BCAST_INIT
                                     : frame_filter_pkg::AVB_VAL_INIT[(g < NF) ? 0 : g - NF]),
                .MASK_INIT ((g < NF) ? frame_filter_pkg::BCAST_INIT
                                     : frame_filter_pkg::AVB_MASK_INIT[(g < NF) ? 0 : g - NF])
            ) u_match (
                .clk_sys    (clk_sys),
                .rst_n      (rst_n),
                .wr_en      (unit_wr[g]),
                .wr         (pat_in),
                .rd_is_mask (pat_rd_is_mask),
                .rd_word    (pat_rd_word),
                .rd_data    (unit_rd[g]),
                .beat_en    (beat_en),
                .byte_idx   (byte_idx_reg[5:0]),
                .rx_byte    (rx.data),
                .enable     (unit_en[g]),
                .hit        (unit_hit[g])
            );
        end
    endgenerate

    // Only the configurable filters feed the verdict bus
    assign pat_hit     = unit_hit[NF-1:0];
    assign any_pat_hit = |pat_hit;

    // Next verdicts from the hits seen on the frame's last beat
    assign verdict_next    = {any_pat_hit, ~pat_hit};
    assign frame_good_next = rx.good && (promiscuous || da_match || any_pat_hit);
    assign av_match_next   = unit_hit[NF+int'(frame_filter_pkg::AVB_CLASS_A)]
                          || unit_hit[NF+int'(frame_filter_pkg::AVB_CLASS_B)];
    assign ptp_match_next  = unit_hit[NF+int'(frame_filter_pkg::AVB_PTP)];

    // Each verdict is captured on the last beat and held until the next frame ends
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            verdict_reg <= '0;
        end else if (frame_end) begin
            verdict_reg <= verdict_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frame_good_reg <= 1'b0;
        end else if (frame_end) begin
            frame_good_reg <= frame_good_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            av_match_reg <= 1'b0;
        end else if (frame_end) begin
            av_match_reg <= av_match_next;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ptp_match_reg <= 1'b0;
        end else if (frame_end) begin
            ptp_match_reg <= ptp_match_next;
        end
    end

    // One-cycle flag marks the first cycle at which the new verdicts stand
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            verdict_valid_reg <= 1'b0;
        end else begin
            verdict_valid_reg <= frame_end;
        end
    end

endmodule // rx_frame_pattern_filter

// file: filter_assertions.sv
// Purpose: Port-level checks of the frame filter verdicts
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the filter
`timescale 1ns/1ps
module filter_assertions (
    input wire logic                             clk_sys,
    input wire logic                             rst_n,
    input wire logic                             promiscuous,
    input wire logic [3:0]                       filter_en,
    input wire logic [2:0]                       avb_filter_en,
    input wire frame_filter_pkg::rx_beat_t       rx,
    input wire logic                             da_match,
    input wire logic [4:0]                       verdict_reg,
    input wire logic                             verdict_valid_reg,
    input wire logic                             frame_good_reg
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence last_s;
        rx.valid && rx.last;
    endsequence
    sequence plain_s;
        last_s ##0 (!promiscuous && !da_match && avb_filter_en == 3'h0);
    endsequence
    valid_pulse_a: assert property (last_s |=> verdict_valid_reg) else $error("verdict flag missing");
    valid_idle_a: assert property (!(rx.valid && rx.last) |=> !verdict_valid_reg) else $error("stray flag");
    verdict_hold_a: assert property (!(rx.valid && rx.last) |=> $stable(verdict_reg) && $stable(frame_good_reg))
        else $error("verdict changed mid frame");
    promisc_good_a: assert property (last_s ##0 (promiscuous && rx.good) |=> frame_good_reg)
        else $error("promiscuous frame dropped");
    bad_frame_a: assert property (last_s ##0 !rx.good |=> !frame_good_reg) else $error("bad frame kept");
    da_good_a: assert property (last_s ##0 (da_match && rx.good) |=> frame_good_reg)
        else $error("address match dropped");
    pattern_good_a: assert property (plain_s |=> frame_good_reg == ($past(rx.good) && verdict_reg[4]))
        else $error("good flag wrong");
    disabled_drop_a: assert property (last_s |=> (~verdict_reg[3:0] & ~$past(filter_en)) == 4'h0)
        else $error("disabled filter matched");
    catch_all_a: assert property (verdict_valid_reg |-> verdict_reg[4] == (verdict_reg[3:0] != 4'hF))
        else $error("catch-all bit wrong");
endmodule // filter_assertions

bind rx_frame_pattern_filter filter_assertions chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .promiscuous(promiscuous), .filter_en(filter_en),
    .avb_filter_en(avb_filter_en), .rx(rx), .da_match(da_match), .verdict_reg(verdict_reg),
    .verdict_valid_reg(verdict_valid_reg), .frame_good_reg(frame_good_reg));

// file: rx_source_model.sv
// Purpose: Receive datapath model sending one 16-byte frame per start
// Assumes: Byte n of the frame sits at bits 8n+7:8n
// Notes:   Idle data toggles so a stale byte is never mistaken for data
`timescale 1ns/1ps
module rx_source_model (
    input  wire logic                  clk_sys,
    input  wire logic                  start,
    input  wire logic                  good,
    input  wire logic [511:0]          frame,
    output frame_filter_pkg::rx_beat_t rx
);
    logic [5:0] pos;
    logic       busy;
    initial begin
        rx = '0;
        busy = 1'b0;
        pos = 6'h00;
    end
    always @(negedge clk_sys) begin
        if (busy) begin
            rx <= '{valid: 1'b1, last: &pos[3:0], good: good, data: frame[{pos, 3'b000} +: 8]};
            busy <= ~&pos[3:0];
            pos <= pos + 6'h01;
        end else begin
            rx <= '{valid: 1'b0, last: 1'b0, good: 1'b0, data: ~rx.data};
            busy <= start;
            pos <= 6'h00;
        end
    end
endmodule // rx_source_model

// file: tb_top.sv
// Purpose: Self-checking bench of the receive frame pattern filter
// Assumes: Frames come from the source model, inputs change at the falling edge
// Notes:   Verdicts are judged once the valid flag is seen
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0, rst_n = 1'b0, promiscuous = 1'b0, da_match = 1'b0, ctrl_wr = 1'b0;
    logic pat_wr = 1'b0, pat_rd_is_mask = 1'b0, start = 1'b0, good = 1'b1;
    logic [3:0] filter_en = 4'h0, pat_rd_word = 4'h0;
    logic [2:0] avb_filter_en = 3'h0;
    logic [511:0] frame = '0;
    frame_filter_pkg::filter_ctrl_t ctrl_in = '0, ctrl_reg;
    frame_filter_pkg::pattern_write_t pat_in = '0;
    frame_filter_pkg::rx_beat_t rx;
    logic [31:0] pat_rd_data_reg;
    logic [4:0] verdict_reg;
    logic verdict_valid_reg, frame_good_reg, av_match_reg, ptp_match_reg;
    int bad_count = 0, num_checks = 0;
    always #25 clk_sys = ~clk_sys;
    rx_source_model src (.clk_sys(clk_sys), .start(start), .good(good), .frame(frame), .rx(rx));
    rx_frame_pattern_filter dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .promiscuous(promiscuous), .filter_en(filter_en),
        .avb_filter_en(avb_filter_en), .ctrl_wr(ctrl_wr), .ctrl_in(ctrl_in), .pat_wr(pat_wr),
        .pat_in(pat_in), .pat_rd_is_mask(pat_rd_is_mask), .pat_rd_word(pat_rd_word), .rx(rx),
        .da_match(da_match), .ctrl_reg(ctrl_reg), .pat_rd_data_reg(pat_rd_data_reg),
        .verdict_reg(verdict_reg), .verdict_valid_reg(verdict_valid_reg),
        .frame_good_reg(frame_good_reg), .av_match_reg(av_match_reg), .ptp_match_reg(ptp_match_reg));
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic sel(input logic r, input logic [3:0] i);
        @(negedge clk_sys);
        ctrl_wr = 1'b1;
        ctrl_in = '{avb_bank_redirect: r, index: i};
        @(negedge clk_sys);
        ctrl_wr = 1'b0;
        cmp({27'h0, ctrl_reg}, {27'h0, r, i});
    endtask
    task automatic wr(input logic m, input logic [3:0] w, input logic [31:0] d);
        @(negedge clk_sys);
        pat_wr = 1'b1;
        pat_in = '{is_mask: m, word: w, data: d};
        @(negedge clk_sys);
        pat_wr = 1'b0;
    endtask
    task automatic rdc(input logic m, input logic [3:0] w, input logic [31:0] e);
        @(negedge clk_sys);
        pat_rd_is_mask = m;
        pat_rd_word = w;
        @(negedge clk_sys);
        cmp(pat_rd_data_reg, e);
    endtask
    function automatic logic [511:0] mk(input logic [7:0] b12, b13, b14, b15);
        return {384'h0, b15, b14, b13, b12, 96'h0};
    endfunction
    task automatic send(input logic [511:0] f, input logic g, input logic [4:0] ev, input logic eg);
        int n;
        n = 0;
        frame = f;
        good = g;
        @(negedge clk_sys);
        start <= 1'b1;
        @(negedge clk_sys);
        start <= 1'b0;
        while (verdict_valid_reg !== 1'b1) begin
            @(negedge clk_sys);
            n++;
            if (n > 100) begin
                bad_count++;
                final_report();
            end
        end
        cmp({27'h0, verdict_reg}, {27'h0, ev});
        cmp({31'h0, frame_good_reg}, {31'h0, eg});
    endtask
    task automatic t_reset_values();
        rdc(1'b0, 4'h0, 32'hFFFF_FFFF);
        rdc(1'b0, 4'h1, 32'h0000_FFFF);
        rdc(1'b1, 4'h1, 32'h0000_FFFF);
        rdc(1'b1, 4'h2, 32'h0000_0000);
        sel(1'b1, 4'h1);
        rdc(1'b0, 4'h3, 32'h0260_0081);
        rdc(1'b1, 4'h3, 32'hFFFF_FFFF);
        sel(1'b1, 4'h2);
        rdc(1'b0, 4'h3, 32'h0240_0081);
        sel(1'b1, 4'h0);
        rdc(1'b1, 4'h3, 32'h0000_FFFF);
        $display("reset values done");
    endtask
    task automatic t_refused();
        sel(1'b1, 4'h3);
        wr(1'b0, 4'h3, 32'h1234_5678);
        rdc(1'b0, 4'h3, 32'h0000_0000);
        sel(1'b1, 4'h5);
        rdc(1'b0, 4'h3, 32'h0260_0081);
        sel(1'b0, 4'h3);
        rdc(1'b0, 4'h3, 32'h0000_0000);
        sel(1'b0, 4'h5);
        rdc(1'b0, 4'h0, 32'h0000_0000);
        $display("refused selection done");
    endtask
    task automatic t_vlan();
        filter_en = 4'h0;
        sel(1'b0, 4'h0);
        wr(1'b1, 4'h0, 32'h0000_0000);
        wr(1'b1, 4'h1, 32'h0000_0000);
        wr(1'b1, 4'h3, 32'hE0FF_FF00);
        wr(1'b0, 4'h3, 32'hE000_8100);
        rdc(1'b1, 4'h3, 32'hE0FF_FF00);
        rdc(1'b0, 4'h3, 32'hE000_8100);
        filter_en = 4'h1;
        send(mk(8'h00, 8'h81, 8'h00, 8'hE0), 1'b1, 5'h1E, 1'b1);
        send(mk(8'h55, 8'h81, 8'h00, 8'hFF), 1'b1, 5'h1E, 1'b1);
        send(mk(8'h00, 8'h81, 8'h00, 8'hA0), 1'b1, 5'h0F, 1'b0);
        filter_en = 4'hF;
        send(512'hFFFF_FFFF_FFFF, 1'b1, 5'h11, 1'b1);
        $display("vlan filter done");
    endtask
    task automatic t_flags();
        promiscuous = 1'b1;
        send(mk(8'h00, 8'h81, 8'h00, 8'hA0), 1'b1, 5'h0F, 1'b1);
        send(mk(8'h00, 8'h81, 8'h00, 8'hE0), 1'b0, 5'h1E, 1'b0);
        promiscuous = 1'b0;
        da_match = 1'b1;
        send(mk(8'h00, 8'h81, 8'h00, 8'hA0), 1'b1, 5'h0F, 1'b1);
        $display("promiscuous and address done");
    endtask
    task automatic avb(input logic [2:0] en, input logic [511:0] f, input logic eav, input logic eptp);
        avb_filter_en = en;
        send(f, 1'b1, 5'h0F, 1'b1);
        cmp({31'h0, av_match_reg}, {31'h0, eav});
        cmp({31'h0, ptp_match_reg}, {31'h0, eptp});
    endtask
    task automatic t_avb();
        filter_en = 4'h0;
        avb(3'h7, mk(8'h81, 8'h00, 8'h60, 8'h02), 1'b1, 1'b0);
        avb(3'h3, mk(8'h81, 8'h00, 8'h40, 8'h02), 1'b0, 1'b0);
        avb(3'h4, mk(8'h81, 8'h00, 8'h40, 8'h02), 1'b1, 1'b0);
        avb(3'h1, mk(8'h88, 8'hF7, 8'h00, 8'h00), 1'b0, 1'b1);
        $display("avb filters done");
    endtask
    initial begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst_n = 1'b1;
        t_reset_values();
        t_refused();
        t_vlan();
        t_flags();
        t_avb();
        final_report();
    end
endmodule // tb_top
